// >>> ieb_pkg.sv
package ieb_pkg;

	localparam int unsigned NUM_ACCESS = 6;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned MSG_OCTETS = 3;

	localparam logic [7:0] MSG_ID_REQ = 8'h14;
	localparam logic [7:0] MSG_ID_RSP = 8'h94;
	localparam int unsigned ACC_POS = 4;

	localparam logic [7:0] RQ_WAKE = 8'h10;
	localparam logic [7:0] RQ_SHUT = 8'h11;
	localparam logic [7:0] RQ_TWAKE = 8'h12;
	localparam logic [7:0] RQ_TLOSS = 8'h13;
	localparam logic [7:0] RQ_READY = 8'h01;
	localparam logic [7:0] RQ_IDLE = 8'h02;
	localparam logic [7:0] RQ_COLD = 8'h03;
	localparam logic [7:0] RQ_RESTART = 8'h00;
	localparam logic [7:0] RQ_LOOP_ALL = 8'h31;
	localparam logic [7:0] RQ_LOOP_B1 = 8'h32;
	localparam logic [7:0] RQ_LOOP_B2 = 8'h33;
	localparam logic [7:0] RQ_NORMAL = 8'h3F;
	localparam logic [7:0] RQ_HOLD = 8'h30;

	localparam logic [7:0] RS_WAKE = 8'h90;
	localparam logic [7:0] RS_WAKE_FAIL = 8'hD0;
	localparam logic [7:0] RS_SHUT = 8'h91;
	localparam logic [7:0] RS_SHUT_FAIL = 8'hD1;
	localparam logic [7:0] RS_TWAKE = 8'h9A;
	localparam logic [7:0] RS_TLOSS = 8'h93;
	localparam logic [7:0] RS_READY = 8'h81;
	localparam logic [7:0] RS_IDLE = 8'h82;
	localparam logic [7:0] RS_COLD = 8'h83;
	localparam logic [7:0] RS_RESTART = 8'h80;
	localparam logic [7:0] RS_LOOP_ALL = 8'hB1;
	localparam logic [7:0] RS_LOOP_B1 = 8'hB2;
	localparam logic [7:0] RS_LOOP_B2 = 8'hB3;
	localparam logic [7:0] RS_NORMAL = 8'hBF;
	localparam logic [7:0] RS_LOOP_ALL_F = 8'hF1;
	localparam logic [7:0] RS_LOOP_B1_F = 8'hF2;
	localparam logic [7:0] RS_LOOP_B2_F = 8'hF3;
	localparam logic [7:0] RS_NORMAL_F = 8'hFF;
	localparam logic [7:0] RS_HOLD = 8'hB0;
	localparam logic [7:0] RS_UNABLE = 8'hF4;

	typedef enum logic [1:0] {
		LOOP_NONE = 2'h0,
		LOOP_ALL = 2'h1,
		LOOP_B1 = 2'h2,
		LOOP_B2 = 2'h3
	} ieb_loop_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} ieb_state_t;

	// Access k (1..6) uses octet slots 2k-1 and 2k; ch is 0 for B1.
	function automatic logic [3:0] octet_slot(logic [2:0] k, logic ch);
		octet_slot = 4'({k, 1'b0} - 4'h1 + 4'(ch));
	endfunction

	// Single-bit slot 1 carries fast signalling; access k uses 2k, 2k+1.
	function automatic logic [3:0] zbit_slot(logic [2:0] k, logic bitn);
		zbit_slot = 4'({k, 1'b0} + 4'(bitn));
	endfunction

	// Slots after the leading signalling bit rotate over the m pairs.
	function automatic logic [3:0] pair_of(logic [3:0] slot, logic [3:0] m);
		pair_of = (m == 4'h0) ? 4'h0 : 4'((slot - 4'h1) % m);
	endfunction

	// Response that echoes a notice or status request from the far unit.
	function automatic logic [7:0] echo_of(logic [7:0] rq);
		unique case (rq)
			RQ_TWAKE: echo_of = RS_TWAKE;
			RQ_TLOSS: echo_of = RS_TLOSS;
			RQ_READY: echo_of = RS_READY;
			RQ_IDLE: echo_of = RS_IDLE;
			RQ_COLD: echo_of = RS_COLD;
			default: echo_of = RS_UNABLE;
		endcase
	endfunction

endpackage

// >>> ieb_link_if.sv
`timescale 1ns/1ps
interface ieb_link_if;
	logic [7:0] l2c_data;
	logic l2c_valid;
	logic l2c_ready;
	logic [7:0] c2l_data;
	logic c2l_valid;
	logic c2l_ready;

	modport line_end (
		output l2c_data,
		output l2c_valid,
		input l2c_ready,
		input c2l_data,
		input c2l_valid,
		output c2l_ready
	);

	modport cust_end (
		input l2c_data,
		input l2c_valid,
		output l2c_ready,
		output c2l_data,
		output c2l_valid,
		input c2l_ready
	);
endinterface

// >>> ieb_fifo.sv
`timescale 1ns/1ps
module ieb_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = ieb_pkg::FIFO_DEPTH
) (
	// Clock and control
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;

	assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end
endmodule

// >>> ieb_line_end.sv
`timescale 1ns/1ps
module ieb_line_end (
	// Clock and control
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic dsl_data_mode,
	// Request port from the exchange side
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [2:0] cmd_access,
	input wire logic [7:0] cmd_code,
	// Messages received from the customer-side unit
	output logic msg_valid,
	output logic msg_is_rsp,
	output logic [2:0] msg_access,
	output logic [7:0] msg_code,
	// Link
	ieb_link_if.line_end link
);
	ieb_pkg::ieb_state_t st_q, st_d;
	logic [23:0] tx_q, tx_d;
	logic [1:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
	logic [23:0] rx_q, rx_d;
	logic full_q, full_d;
	logic mv_q, mv_d, mr_q, mr_d;
	logic [2:0] ma_q, ma_d;
	logic [7:0] mc_q, mc_d;

	// Nothing leaves before the section reaches data mode.
	assign link.l2c_valid = (st_q == ieb_pkg::ST_SEND) && dsl_data_mode;
	assign link.l2c_data = tx_q[23:16];
	assign link.c2l_ready = !full_q;
	// An echo owed to the far unit goes ahead of local requests.
	assign cmd_ready = (st_q == ieb_pkg::ST_IDLE) && !full_q && dsl_data_mode;
	assign msg_valid = mv_q;
	assign msg_is_rsp = mr_q;
	assign msg_access = ma_q;
	assign msg_code = mc_q;

	always_comb begin
		st_d = st_q;
		tx_d = tx_q;
		tcnt_d = tcnt_q;
		rcnt_d = rcnt_q;
		rx_d = rx_q;
		full_d = full_q;
		mv_d = 1'b0;
		mr_d = mr_q;
		ma_d = ma_q;
		mc_d = mc_q;
		if (link.c2l_valid && !full_q) begin
			if (rcnt_q != 2'd0 || link.c2l_data == ieb_pkg::MSG_ID_REQ ||
					link.c2l_data == ieb_pkg::MSG_ID_RSP) begin
				rx_d = {rx_q[15:0], link.c2l_data};
				rcnt_d = (rcnt_q == 2'd2) ? 2'd0 : rcnt_q + 2'd1;
				full_d = rcnt_q == 2'd2;
			end
		end
		if (st_q == ieb_pkg::ST_IDLE) begin
			if (full_q) begin
				full_d = 1'b0;
				mv_d = 1'b1;
				mr_d = rx_q[23:16] == ieb_pkg::MSG_ID_RSP;
				ma_d = rx_q[14:12];
				mc_d = rx_q[7:0];
				if (rx_q[23:16] == ieb_pkg::MSG_ID_REQ) begin
					// Notices and status are echoed as their response.
					tx_d = {ieb_pkg::MSG_ID_RSP, rx_q[15:12], 4'h0,
						ieb_pkg::echo_of(rx_q[7:0])};
					tcnt_d = 2'd0;
					st_d = ieb_pkg::ST_SEND;
				end
			end else if (cmd_valid && dsl_data_mode) begin
				// The line side may wake, shut down or reset each bus.
				tx_d = {ieb_pkg::MSG_ID_REQ, 1'b0, cmd_access, 4'h0, cmd_code};
				tcnt_d = 2'd0;
				st_d = ieb_pkg::ST_SEND;
			end
		end else if (link.l2c_ready && dsl_data_mode) begin
			tx_d = {tx_q[15:0], 8'h00};
			tcnt_d = tcnt_q + 2'd1;
			if (tcnt_q == 2'd2) begin
				st_d = ieb_pkg::ST_IDLE;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= ieb_pkg::ST_IDLE;
			tx_q <= '0;
			tcnt_q <= '0;
			rcnt_q <= '0;
			rx_q <= '0;
			full_q <= 1'b0;
			mv_q <= 1'b0;
			mr_q <= 1'b0;
			ma_q <= '0;
			mc_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
			tx_q <= tx_d;
			tcnt_q <= tcnt_d;
			rcnt_q <= rcnt_d;
			rx_q <= rx_d;
			full_q <= full_d;
			mv_q <= mv_d;
			mr_q <= mr_d;
			ma_q <= ma_d;
			mc_q <= mc_d;
		end
	end
endmodule

// >>> ieb_cust_end.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Up to three accesses: two slots each.
// - Four to six accesses: same slot pattern.
// - Fast signalling bit leads every pair.
// - Remaining slots interleave across all pairs.
// - No signalling before data mode.
// - Messages ride either channel, same format.
// - Requests id 20, responses id 148.
// - Access number in high nibble, low zero.
// - Third octet holds the message code.
// - Bus control request codes.
// - Status and restart request codes.
// - Maintenance request codes, B loops optional.
// - Bus control response codes.
// - Status and restart response codes.
// - Maintenance response and failure codes.
// - Each bus controlled per access.
// - Wake activates; shutdown deactivates, drops loops.
// - Terminal notices sent, echoed by line.
// - Readiness and cold start echoed in kind.
// - Restart resets only the addressed access.
// - Loop user data back toward network.
// - Normal releases, hold freezes, bad frames answered.
// - D bits follow in the next sub-block.
module ieb_cust_end #(
	parameter bit B_LOOP_SUPPORTED = 1'b1
) (
	// Clock and control
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic dsl_data_mode,
	// Local notices toward the line side
	input wire logic note_valid,
	output logic note_ready,
	input wire logic [2:0] note_access,
	input wire logic [7:0] note_code,
	// Echo of a notice seen from the line side
	output logic echo_valid,
	output logic [2:0] echo_access,
	output logic [7:0] echo_code,
	// Per-access S interface control and global EOC hold
	output logic [5:0] s_active,
	output logic [11:0] loop_mode,
	output logic eoc_hold,
	// Payload D-bit placement
	input wire logic sb_strobe,
	input wire logic fs_bit,
	input wire logic [11:0] d_bits,
	output logic [12:0] zbits,
	// Slot lookup
	input wire logic [2:0] map_access,
	input wire logic [3:0] map_pairs,
	output logic [3:0] map_b1_slot,
	output logic [3:0] map_b2_slot,
	output logic [3:0] map_z1_slot,
	output logic [3:0] map_z2_slot,
	output logic [3:0] map_b1_pair,
	output logic [3:0] map_z1_pair,
	// Link
	ieb_link_if.cust_end link
);
	ieb_pkg::ieb_state_t st_q, st_d;
	logic [23:0] tx_q, tx_d, rx_q, rx_d;
	logic [1:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
	logic full_q, full_d, hold_q, hold_d;
	logic [5:0] act_q, act_d;
	logic [11:0] loop_q, loop_d;
	logic ev_q, ev_d;
	logic [2:0] ea_q, ea_d;
	logic [7:0] ec_q, ec_d;
	logic [11:0] dh_q, dh_d;
	logic [12:0] z_q, z_d;
	logic [3:0] mb1_q, mb2_q, mz1_q, mz2_q, mpb_q, mpz_q;
	logic [7:0] fo_data;
	logic fo_valid, fo_ready;
	logic [2:0] acc;
	logic [7:0] rc;
	logic bad_addr;

	// Inbound octets queue here so the processor can stall the line side.
	ieb_fifo #(.WIDTH(8), .DEPTH(ieb_pkg::FIFO_DEPTH)) u_rx_fifo (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.in_data(link.l2c_data),
		.in_valid(link.l2c_valid),
		.in_ready(link.l2c_ready),
		.out_data(fo_data),
		.out_valid(fo_valid),
		.out_ready(fo_ready)
	);

	assign fo_ready = !full_q;
	assign link.c2l_valid = (st_q == ieb_pkg::ST_SEND) && dsl_data_mode;
	assign link.c2l_data = tx_q[23:16];
	assign note_ready = (st_q == ieb_pkg::ST_IDLE) && !full_q && dsl_data_mode;
	assign echo_valid = ev_q;
	assign echo_access = ea_q;
	assign echo_code = ec_q;
	assign s_active = act_q;
	assign loop_mode = loop_q;
	assign eoc_hold = hold_q;
	assign zbits = z_q;
	assign map_b1_slot = mb1_q;
	assign map_b2_slot = mb2_q;
	assign map_z1_slot = mz1_q;
	assign map_z2_slot = mz2_q;
	assign map_b1_pair = mpb_q;
	assign map_z1_pair = mpz_q;
	assign acc = rx_q[14:12];
	assign bad_addr = rx_q[15] || acc >= 3'(ieb_pkg::NUM_ACCESS) ||
		rx_q[11:8] != 4'h0;

	// Message path: the channel carrying it does not change the format.
	always_comb begin
		st_d = st_q;
		tx_d = tx_q;
		tcnt_d = tcnt_q;
		rcnt_d = rcnt_q;
		rx_d = rx_q;
		full_d = full_q;
		hold_d = hold_q;
		act_d = act_q;
		loop_d = loop_q;
		ev_d = 1'b0;
		ea_d = ea_q;
		ec_d = ec_q;
		rc = ieb_pkg::RS_UNABLE;
		if (fo_valid && !full_q) begin
			if (rcnt_q != 2'd0 || fo_data == ieb_pkg::MSG_ID_REQ ||
					fo_data == ieb_pkg::MSG_ID_RSP) begin
				rx_d = {rx_q[15:0], fo_data};
				rcnt_d = (rcnt_q == 2'd2) ? 2'd0 : rcnt_q + 2'd1;
				full_d = rcnt_q == 2'd2;
			end
		end
		if (st_q == ieb_pkg::ST_IDLE) begin
			if (full_q) begin
				full_d = 1'b0;
				if (rx_q[23:16] == ieb_pkg::MSG_ID_RSP) begin
					ev_d = 1'b1;
					ea_d = acc;
					ec_d = rx_q[7:0];
				end else begin
					if (bad_addr) begin
						rc = ieb_pkg::RS_HOLD;
					end else if (hold_q && rx_q[7:0] != ieb_pkg::RQ_NORMAL) begin
						rc = ieb_pkg::RS_HOLD;
					end else begin
						unique case (rx_q[7:0])
							ieb_pkg::RQ_WAKE: begin
								act_d[acc] = 1'b1;
								rc = ieb_pkg::RS_WAKE;
							end
							ieb_pkg::RQ_SHUT: begin
								act_d[acc] = 1'b0;
								loop_d[2*acc +: 2] = ieb_pkg::LOOP_NONE;
								rc = ieb_pkg::RS_SHUT;
							end
							ieb_pkg::RQ_RESTART: begin
								act_d[acc] = 1'b0;
								loop_d[2*acc +: 2] = ieb_pkg::LOOP_NONE;
								rc = ieb_pkg::RS_RESTART;
							end
							ieb_pkg::RQ_READY: rc = ieb_pkg::RS_READY;
							ieb_pkg::RQ_IDLE: rc = ieb_pkg::RS_IDLE;
							ieb_pkg::RQ_LOOP_ALL: begin
								loop_d[2*acc +: 2] = ieb_pkg::LOOP_ALL;
								rc = ieb_pkg::RS_LOOP_ALL;
							end
							ieb_pkg::RQ_LOOP_B1: begin
								if (B_LOOP_SUPPORTED) begin
									loop_d[2*acc +: 2] = ieb_pkg::LOOP_B1;
									rc = ieb_pkg::RS_LOOP_B1;
								end else begin
									rc = ieb_pkg::RS_LOOP_B1_F;
								end
							end
							ieb_pkg::RQ_LOOP_B2: begin
								if (B_LOOP_SUPPORTED) begin
									loop_d[2*acc +: 2] = ieb_pkg::LOOP_B2;
									rc = ieb_pkg::RS_LOOP_B2;
								end else begin
									rc = ieb_pkg::RS_LOOP_B2_F;
								end
							end
							ieb_pkg::RQ_NORMAL: begin
								loop_d = '0;
								hold_d = 1'b0;
								rc = ieb_pkg::RS_NORMAL;
							end
							ieb_pkg::RQ_HOLD: begin
								hold_d = 1'b1;
								rc = ieb_pkg::RS_HOLD;
							end
							default: rc = ieb_pkg::RS_UNABLE;
						endcase
					end
					tx_d = {ieb_pkg::MSG_ID_RSP, rx_q[15:12], 4'h0, rc};
					tcnt_d = 2'd0;
					st_d = ieb_pkg::ST_SEND;
				end
			end else if (note_valid && dsl_data_mode) begin
				// Local notices go out as requests.
				tx_d = {ieb_pkg::MSG_ID_REQ, 1'b0, note_access, 4'h0,
					note_code};
				tcnt_d = 2'd0;
				st_d = ieb_pkg::ST_SEND;
			end
		end else if (link.c2l_ready && dsl_data_mode) begin
			tx_d = {tx_q[15:0], 8'h00};
			tcnt_d = tcnt_q + 2'd1;
			if (tcnt_q == 2'd2) begin
				st_d = ieb_pkg::ST_IDLE;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q <= ieb_pkg::ST_IDLE;
			tx_q <= '0;
			tcnt_q <= '0;
			rcnt_q <= '0;
			rx_q <= '0;
			full_q <= 1'b0;
			hold_q <= 1'b0;
			act_q <= '0;
			loop_q <= '0;
			ev_q <= 1'b0;
			ea_q <= '0;
			ec_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
			tx_q <= tx_d;
			tcnt_q <= tcnt_d;
			rcnt_q <= rcnt_d;
			rx_q <= rx_d;
			full_q <= full_d;
			hold_q <= hold_d;
			act_q <= act_d;
			loop_q <= loop_d;
			ev_q <= ev_d;
			ea_q <= ea_d;
			ec_q <= ec_d;
		end
	end

	// D bits taken in one sub-block leave in the next, so frame wrap
	// needs no special case: the strobe simply keeps running.
	always_comb begin
		dh_d = dh_q;
		z_d = z_q;
		if (sb_strobe) begin
			dh_d = d_bits;
			z_d = {dh_q, fs_bit};
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dh_q <= '0;
			z_q <= '0;
			mb1_q <= '0;
			mb2_q <= '0;
			mz1_q <= '0;
			mz2_q <= '0;
			mpb_q <= '0;
			mpz_q <= '0;
		end else if (ce) begin
			dh_q <= dh_d;
			z_q <= z_d;
			mb1_q <= ieb_pkg::octet_slot(map_access, 1'b0);
			mb2_q <= ieb_pkg::octet_slot(map_access, 1'b1);
			mz1_q <= ieb_pkg::zbit_slot(map_access, 1'b0);
			mz2_q <= ieb_pkg::zbit_slot(map_access, 1'b1);
			mpb_q <= ieb_pkg::pair_of(ieb_pkg::octet_slot(map_access, 1'b0),
				map_pairs);
			mpz_q <= ieb_pkg::pair_of(ieb_pkg::zbit_slot(map_access, 1'b0) -
				4'h1, map_pairs);
		end
	end
endmodule

// >>> ieb_link_properties.sv
`timescale 1ns/1ps
module ieb_link_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	input wire logic dsl_data_mode,
	// Line to customer
	input wire logic [7:0] l2c_data,
	input wire logic l2c_valid,
	input wire logic l2c_ready,
	// Customer to line
	input wire logic [7:0] c2l_data,
	input wire logic c2l_valid,
	input wire logic c2l_ready
);
	logic [1:0] lc_q;
	logic [1:0] cc_q;
	wire logic l2c_go = l2c_valid && l2c_ready;
	wire logic c2l_go = c2l_valid && c2l_ready;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	// Octet position within a message, so each octet is judged by its place.
	always_ff @(posedge mclk) begin
		if (srst) begin
			lc_q <= 2'h0;
			cc_q <= 2'h0;
		end else begin
			if (l2c_go)
				lc_q <= (lc_q == 2'h2) ? 2'h0 : lc_q + 2'h1;
			if (c2l_go)
				cc_q <= (cc_q == 2'h2) ? 2'h0 : cc_q + 2'h1;
		end
	end

	a_l2c_data_held: assert property (l2c_valid && !l2c_ready && dsl_data_mode
		##1 dsl_data_mode |-> l2c_valid && $stable(l2c_data))
		else $error("line octet dropped or changed before acceptance");
	a_c2l_data_held: assert property (c2l_valid && !c2l_ready && dsl_data_mode
		##1 dsl_data_mode |-> c2l_valid && $stable(c2l_data))
		else $error("customer octet dropped or changed before acceptance");
	a_l2c_quiet_idle: assert property (!dsl_data_mode [*2] |-> !l2c_valid)
		else $error("line end sends outside data mode");
	a_c2l_quiet_idle: assert property (!dsl_data_mode [*2] |-> !c2l_valid)
		else $error("customer end sends outside data mode");
	a_l2c_msg_id: assert property (l2c_go && lc_q == 2'h0 |->
		l2c_data == 8'h14 || l2c_data == 8'h94)
		else $error("line message starts with a wrong identifier");
	a_c2l_msg_id: assert property (c2l_go && cc_q == 2'h0 |->
		c2l_data == 8'h94 || c2l_data == 8'h14)
		else $error("customer message starts with a wrong identifier");
	a_addr_low_zero: assert property (l2c_go && lc_q == 2'h1 |->
		l2c_data[3:0] == 4'h0)
		else $error("unused address bits not zero");
	a_c2l_octets_tight: assert property (cc_q != 2'h0 && c2l_ready &&
		dsl_data_mode |-> c2l_valid)
		else $error("customer message not sent in consecutive octets");
	a_l2c_gap_after: assert property (l2c_go && lc_q == 2'h2 |=> !l2c_valid)
		else $error("line end starts a message without an idle cycle");

	c_line_request: cover property (l2c_go && lc_q == 2'h0 && l2c_data == 8'h14);
	c_line_echo: cover property (l2c_go && lc_q == 2'h0 && l2c_data == 8'h94);
	c_cust_hold: cover property (c2l_go && cc_q == 2'h2 && c2l_data == 8'hB0);
endmodule

// >>> tb_isdn_ba_eoc_signalling.sv
`timescale 1ns/1ps
`define CHK(a, e) chk(64'(a), 64'(e))
module tb_isdn_ba_eoc_signalling;
	logic mclk, srst, dsl_data_mode, cmd_valid, cmd_ready, note_valid;
	logic note_ready, msg_valid, msg_is_rsp, echo_valid, eoc_hold;
	logic sb_strobe, fs_bit, hold;
	logic [2:0] cmd_access, note_access, msg_access, echo_access, map_access;
	logic [7:0] cmd_code, note_code, msg_code, echo_code, r;
	logic [5:0] s_active, act;
	logic [11:0] loop_mode, d_bits, lp;
	logic [12:0] zbits;
	logic [3:0] map_pairs, map_b1_slot, map_b2_slot, map_z1_slot;
	logic [3:0] map_z2_slot, map_b1_pair, map_z1_pair;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	int ta [19] = '{0, 1, 5, 0, 1, 2, 0, 1, 0, 0, 3, 3, 2, 4, 4, 6, 4, 3, 7};
	int tc [19] = '{8'h10, 8'h10, 8'h10, 8'h31, 8'h32, 8'h33, 8'h11, 8'h00,
		8'h01, 8'h02, 8'h03, 8'h12, 8'h3F, 8'h30, 8'h10, 8'h10, 8'h3F,
		8'h13, 8'h11};
	int nc [5] = '{8'h12, 8'h13, 8'h01, 8'h03, 8'h02};
	int ne [5] = '{8'h9A, 8'h93, 8'h81, 8'h83, 8'h82};

	ieb_link_if link ();
	ieb_line_end ieb_line_end_inst (.mclk, .srst, .ce(1'b1), .dsl_data_mode,
		.cmd_valid, .cmd_ready, .cmd_access, .cmd_code, .msg_valid,
		.msg_is_rsp, .msg_access, .msg_code, .link(link.line_end));
	ieb_cust_end ieb_cust_end_inst (.mclk, .srst, .ce(1'b1), .dsl_data_mode,
		.note_valid, .note_ready, .note_access, .note_code, .echo_valid,
		.echo_access, .echo_code, .s_active, .loop_mode, .eoc_hold,
		.sb_strobe, .fs_bit, .d_bits, .zbits, .map_access, .map_pairs,
		.map_b1_slot, .map_b2_slot, .map_z1_slot, .map_z2_slot,
		.map_b1_pair, .map_z1_pair, .link(link.cust_end));
	ieb_link_properties ieb_link_properties_inst (.mclk, .srst,
		.dsl_data_mode, .l2c_data(link.l2c_data),
		.l2c_valid(link.l2c_valid), .l2c_ready(link.l2c_ready),
		.c2l_data(link.c2l_data), .c2l_valid(link.c2l_valid),
		.c2l_ready(link.c2l_ready));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [63:0] a, input logic [63:0] e);
		checks++;
		if (a !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask

	task automatic conclude;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Holds the request until its ready is seen, then drops it after the edge.
	task automatic send(input bit cust, input int a, input int c);
		if (cust) begin
			note_access = 3'(a);
			note_code = 8'(c);
			note_valid = 1'b1;
		end else begin
			cmd_access = 3'(a);
			cmd_code = 8'(c);
			cmd_valid = 1'b1;
		end
		#1;
		while ((cust ? note_ready : cmd_ready) !== 1'b1 && cyc < 6000) begin
			@(posedge mclk);
			#2;
		end
		step(1);
		note_valid = 1'b0;
		cmd_valid = 1'b0;
	endtask

	task automatic wait_pulse(input bit echo);
		int i;
		i = 0;
		do begin
			step(1);
			i++;
		end while ((echo ? echo_valid : msg_valid) !== 1'b1 && i < 200);
		if (i >= 200)
			n_mismatch++;
	endtask

	// Expected reply and S interface state of the customer end.
	task automatic model(input int a, input int c);
		if (a > 5 || (hold && c != 8'h3F))
			r = 8'hB0;
		else case (c)
			8'h10: begin
				act[a] = 1'b1;
				r = 8'h90;
			end
			8'h11, 8'h00: begin
				act[a] = 1'b0;
				lp[2*a+:2] = 2'h0;
				r = (c == 8'h11) ? 8'h91 : 8'h80;
			end
			8'h01, 8'h02: r = 8'(c + 8'h80);
			8'h31, 8'h32, 8'h33: begin
				lp[2*a+:2] = 2'(c);
				r = 8'(c + 8'h80);
			end
			8'h3F: begin
				lp = 12'h000;
				hold = 1'b0;
				r = 8'hBF;
			end
			8'h30: begin
				hold = 1'b1;
				r = 8'hB0;
			end
			default: r = 8'hF4;
		endcase
	endtask

	initial begin
		{srst, dsl_data_mode, cmd_valid, note_valid, sb_strobe} = 5'h10;
		{cmd_access, note_access, cmd_code, note_code} = 22'h0;
		{fs_bit, d_bits, map_access, map_pairs} = 20'h0;
		{act, lp, hold} = 19'h0;
		step(4);
		srst = 1'b0;
		`CHK({s_active, loop_mode, eoc_hold}, 19'h0);
		cmd_valid = 1'b1;
		cmd_code = 8'h10;
		step(3);
		`CHK({cmd_ready, link.l2c_valid}, 2'h0);
		dsl_data_mode = 1'b1;
		for (int j = 0; j < 19; j++) begin
			model(ta[j], tc[j]);
			send(1'b0, ta[j], tc[j]);
			wait_pulse(1'b0);
			`CHK({msg_is_rsp, msg_access, msg_code}, {1'b1, 3'(ta[j]), r});
			`CHK({s_active, loop_mode, eoc_hold}, {act, lp, hold});
		end
		for (int j = 0; j < 5; j++) begin
			send(1'b1, j, nc[j]);
			wait_pulse(1'b0);
			`CHK({msg_is_rsp, msg_access, msg_code}, {1'b0, 3'(j), 8'(nc[j])});
			wait_pulse(1'b1);
			`CHK({echo_access, echo_code}, {3'(j), 8'(ne[j])});
		end
		{fs_bit, d_bits, sb_strobe} = {1'b1, 12'hA5C, 1'b1};
		step(1);
		`CHK(zbits[0], 1'b1);
		{fs_bit, d_bits, sb_strobe} = {1'b0, 12'h3F0, 1'b0};
		step(2);
		sb_strobe = 1'b1;
		step(1);
		sb_strobe = 1'b0;
		`CHK(zbits, {12'hA5C, 1'b0});
		for (int m = 2; m <= 4; m += 2) begin
			for (int k = 1; k <= 6; k++) begin
				map_access = 3'(k);
				map_pairs = 4'(m);
				step(2);
				`CHK({map_b1_slot, map_b2_slot, map_z1_slot, map_z2_slot}, {4'(2*k-1), 4'(2*k), 4'(2*k), 4'(2*k+1)});
				`CHK({map_b1_pair, map_z1_pair}, {4'((2*k-2)%m), 4'((2*k-2)%m)});
			end
		end
		conclude();
	end
endmodule
